/* File: fds_ack_timer.sv */
// acknowledgement timeout watch for module accesses
`timescale 1ns/100ps
module fds_ack_timer
  import fds_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_start,
  input wire logic io_image,
  input wire logic module_ready,
  output logic io_wait,
  output logic timeout_ind,
  output logic timeout_img
);
  localparam logic [ACK_CNT_W-1:0] ACK_LAST =
    ACK_CNT_W'(ACK_TIMEOUT_CYC - 1);
  logic [ACK_CNT_W-1:0] cnt;
  logic kind_img;
  logic expire;

  assign expire = io_wait && !module_ready && cnt == ACK_LAST;

  // the access is held, not aborted, until ready or expiry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_wait <= 1'b0;
      cnt <= '0;
      kind_img <= 1'b0;
    end else if (!io_wait) begin
      if (io_start) begin
        io_wait <= 1'b1;
        cnt <= '0;
        kind_img <= io_image;
      end
    end else if (module_ready || expire) io_wait <= 1'b0;
    else cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_ind <= 1'b0;
      timeout_img <= 1'b0;
    end else begin
      timeout_ind <= expire && !kind_img;
      timeout_img <= expire && kind_img;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_ack_expire;
    expire |=> !io_wait && (timeout_ind || timeout_img);
  endproperty
  a_ack_expire: assert property (p_ack_expire)
    else $error("ack timeout not flagged at expiry");

  property p_ack_ready;
    (io_wait && module_ready) |=> !io_wait && !timeout_ind && !timeout_img;
  endproperty
  a_ack_ready: assert property (p_ack_ready)
    else $error("ready access flagged or still held");
endmodule : fds_ack_timer

/* File: fds_fault_dispatch_stop_control.sv */
// fault dispatch, stop entry, stop lamp and output disable control
`timescale 1ns/100ps
// What this block does
// - stop at instruction boundary or with core halted; selector stop on return of handler 28
// - battery or power failure stops the unit
// - interrupt or block stack overflow stops
// - bad address list, loop or preset block stops
// - selector stop calls handler 28, then stops
// - faults inside handler 28 dispatch normally
// - lamp steady, slow or fast by cause
// - push break record when program was entered, except on config or init stops
// - absent handler: ack timeouts continue, others stop
// - supply fault info words with each call
// - absent block call runs handler 19, skips
// - absent block caught for all call kinds
// - module ready late flags ack timeout
// - single access 23, image update 24
// - ack timeout stretches, never aborts, instruction
// - unallocated image point runs handler 25, skips
// - scan overrun calls 26, restarts monitor
// - scan overrun sets output disable until return
// - illegal operand substitution calls handler 27
// - opcode, parameter, special function: 29 to 31
// - transfer, time interrupt, loop: 32 to 34
// - seven nesting levels; overflow or repeat stops
module fds_fault_dispatch_stop_control
  import fds_pkg::*;
#(
  parameter int FAST_HALF_CYC = FLASH_FAST_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_boundary,
  input wire logic core_running,
  input wire logic user_prog_entered,
  input wire logic selector_stop,
  input wire logic coordinator_halt,
  input wire logic stop_instr,
  input wire logic battery_fail,
  input wire logic central_power_fail,
  input wire logic expansion_power_fail,
  input wire logic interrupt_stack_overflow,
  input wire logic block_stack_overflow,
  input wire logic module_address_list_err,
  input wire logic loop_param_block_err,
  input wire logic preset_block_err,
  input wire logic init_err,
  input wire logic absent_block_call,
  input wire logic io_start,
  input wire logic io_image,
  input wire logic module_ready,
  input wire logic address_error,
  input wire logic scan_overrun,
  input wire logic subst_error,
  input wire logic illegal_opcode,
  input wire logic illegal_param,
  input wire logic special_func_err,
  input wire logic transfer_err,
  input wire logic time_irq_overrun,
  input wire logic loop_ctrl_err,
  input wire logic handler_load,
  input wire logic [NVEC-1:0] handler_present_in,
  input wire logic handler_done,
  input wire logic [WORD_W-1:0] cur_addr,
  input wire logic [CC_W-1:0] cur_cc,
  input wire logic [WORD_W-1:0] acc1,
  input wire logic [WORD_W-1:0] acc2,
  output logic run_enable,
  output logic stop_state,
  output fds_cause_t stop_cause,
  output logic stop_lamp,
  output logic output_disable,
  output logic scan_restart,
  output logic io_wait,
  output logic handler_call,
  output logic [OB_W-1:0] handler_num,
  output logic [WORD_W-1:0] handler_info1,
  output logic [WORD_W-1:0] handler_info2,
  output logic handler_skip,
  output logic [DEPTH_W-1:0] nest_depth,
  output logic istack_push,
  output logic [WORD_W-1:0] istack_addr,
  output logic [CC_W-1:0] istack_cc,
  output logic [WORD_W-1:0] istack_acc1,
  output logic [WORD_W-1:0] istack_acc2,
  output fds_cause_t istack_cause
);
  fds_state_t state;
  fds_cause_t next_cause;
  fds_cause_t enter_cause;
  fds_lamp_t lamp_mode;
  logic [NVEC-1:0] handler_present;
  logic [NVEC-1:0] raw;
  logic [NVEC-1:0] pending;
  logic [NVEC-1:0] clr_vec;
  logic [NVEC-1:0] active;
  logic [VEC_W-1:0] nest_vec [NEST_MAX];
  logic [VEC_W-1:0] call_vec;
  logic [VEC_W-1:0] pop_vec;
  logic do_call;
  logic pop;
  logic enter_stop;
  logic timeout_ind;
  logic timeout_img;
  logic sel_req;
  logic bus_fail;
  logic stack_ovf;
  logic cfg_err;
  logic hard_cause;
  logic [DEPTH_W-1:0] nest_depth_q;

  function automatic logic [VEC_W-1:0] first_pending(
    input logic [NVEC-1:0] p);
    logic [VEC_W-1:0] r;
    r = V_ABSENT;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (p[i]) r = VEC_W'(i);
    end
    return r;
  endfunction : first_pending

  fds_ack_timer u_ack (
    .clk(clk),
    .reset_n(reset_n),
    .io_start(io_start),
    .io_image(io_image),
    .module_ready(module_ready),
    .io_wait(io_wait),
    .timeout_ind(timeout_ind),
    .timeout_img(timeout_img)
  );

  fds_lamp #(.FAST_HALF_CYC(FAST_HALF_CYC)) u_lamp (
    .clk(clk),
    .reset_n(reset_n),
    .mode(lamp_mode),
    .lamp(stop_lamp)
  );

  assign sel_req = selector_stop | coordinator_halt;
  assign bus_fail = battery_fail | central_power_fail |
                    expansion_power_fail;
  assign stack_ovf = interrupt_stack_overflow |
                     block_stack_overflow;
  assign cfg_err = module_address_list_err | loop_param_block_err |
                   preset_block_err;
  assign hard_cause = init_err | cfg_err | bus_fail | stack_ovf |
                      stop_instr;
  // the core may not start or continue while a hard cause stands
  assign run_enable = (state != ST_STOP) && !hard_cause;
  assign stop_state = (state == ST_STOP);
  assign nest_depth = NEST_MAX & nest_depth_q;

  // absent_block_call covers every block type and call kind
  assign raw = {1'b0, loop_ctrl_err, time_irq_overrun, transfer_err,
                special_func_err, illegal_param, illegal_opcode,
                subst_error, scan_overrun, address_error, timeout_img,
                timeout_ind, absent_block_call};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) handler_present <= '0;
    else if (handler_load) handler_present <= handler_present_in;
  end

  // set wins over clear so a repeat in the dispatch cycle is kept
  generate
    for (genvar i = 0; i < NVEC; i++) begin : g_pend
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pending[i] <= 1'b0;
        else pending[i] <= raw[i] | (pending[i] & ~clr_vec[i]);
      end
    end
  endgenerate

  assign pop = handler_done && nest_depth_q != '0;
  assign pop_vec = nest_vec[nest_depth_q - DEPTH_ONE];

  always_comb begin
    next_cause = CAUSE_NONE;
    do_call = 1'b0;
    call_vec = V_ABSENT;
    clr_vec = '0;
    if (state != ST_STOP && !handler_done &&
        (instr_boundary || !core_running)) begin
      if (init_err) next_cause = CAUSE_INIT;
      else if (cfg_err) next_cause = CAUSE_CONFIG;
      else if (bus_fail) next_cause = CAUSE_BUS;
      else if (stack_ovf) next_cause = CAUSE_STACK;
      else if (stop_instr) next_cause = CAUSE_INSTR;
      else if (sel_req && state == ST_RUN) begin
        if (handler_present[V_SEL] && nest_depth_q != NEST_MAX) begin
          do_call = 1'b1;
          call_vec = V_SEL;
        end else next_cause = CAUSE_SELECTOR;
      end else if (|pending) begin
        call_vec = first_pending(pending);
        clr_vec[call_vec] = 1'b1;
        if (active[call_vec] || nest_depth_q == NEST_MAX)
          next_cause = CAUSE_FAULT;
        else if (handler_present[call_vec]) do_call = 1'b1;
        else if (!CONT_MASK[call_vec]) next_cause = CAUSE_FAULT;
      end
    end
  end

  always_comb begin
    enter_cause = next_cause;
    if (state == ST_SEL && pop && pop_vec == V_SEL)
      enter_cause = CAUSE_SELECTOR;
    enter_stop = (enter_cause != CAUSE_NONE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state <= ST_RUN;
    else begin
      case (state)
        ST_RUN: begin
          if (enter_stop) state <= ST_STOP;
          else if (do_call && call_vec == V_SEL) state <= ST_SEL;
        end
        ST_SEL: if (enter_stop) state <= ST_STOP;
        ST_STOP: state <= ST_STOP;
        default: state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stop_cause <= CAUSE_NONE;
    else if (state != ST_STOP && enter_stop) stop_cause <= enter_cause;
  end

  // nesting stack holds which vector each open handler belongs to
  always_ff @(posedge clk) begin
    if (do_call) nest_vec[nest_depth_q] <= call_vec;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nest_depth_q <= '0;
      active <= '0;
    end else if (do_call) begin
      nest_depth_q <= nest_depth_q + DEPTH_ONE;
      active[call_vec] <= 1'b1;
    end else if (pop) begin
      nest_depth_q <= nest_depth_q - DEPTH_ONE;
      active[pop_vec] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      handler_call <= 1'b0;
      handler_num <= '0;
      handler_info1 <= '0;
      handler_info2 <= '0;
      handler_skip <= 1'b0;
    end else begin
      handler_call <= do_call;
      if (do_call) begin
        handler_num <= fds_ob_num(call_vec);
        handler_info1 <= WORD_W'({fds_ob_num(call_vec),
                                  nest_depth_q});
        handler_info2 <= cur_addr;
        handler_skip <= SKIP_MASK[call_vec];
      end
    end
  end

  // disable is held through stop; only a clean return clears it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) output_disable <= 1'b0;
    else if (scan_overrun) output_disable <= 1'b1;
    else if (pop && nest_depth_q == DEPTH_ONE && state != ST_STOP)
      output_disable <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) scan_restart <= 1'b0;
    else scan_restart <= scan_overrun;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      istack_push <= 1'b0;
      istack_addr <= '0;
      istack_cc <= '0;
      istack_acc1 <= '0;
      istack_acc2 <= '0;
      istack_cause <= CAUSE_NONE;
    end else begin
      istack_push <= 1'b0;
      if (state != ST_STOP && enter_stop && user_prog_entered &&
          enter_cause != CAUSE_CONFIG && enter_cause != CAUSE_INIT) begin
        istack_push <= 1'b1;
        istack_addr <= cur_addr;
        istack_cc <= cur_cc;
        istack_acc1 <= acc1;
        istack_acc2 <= acc2;
        istack_cause <= enter_cause;
      end
    end
  end

  always_comb begin
    lamp_mode = LAMP_OFF;
    if (state == ST_STOP) begin
      case (stop_cause)
        CAUSE_SELECTOR, CAUSE_BUS: lamp_mode = LAMP_STEADY;
        CAUSE_INIT: lamp_mode = LAMP_FAST;
        CAUSE_NONE: lamp_mode = LAMP_OFF;
        default: lamp_mode = LAMP_SLOW;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_stop_hold;
    stop_state |=> stop_state && !handler_call;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop state left or handler called in stop");

  property p_bus_stop;
    (!stop_state && instr_boundary && !handler_done && bus_fail &&
     !init_err && !cfg_err) |=> stop_state && stop_cause == CAUSE_BUS;
  endproperty
  a_bus_stop: assert property (p_bus_stop)
    else $error("bus power failure did not stop");

  property p_stack_stop;
    (!stop_state && instr_boundary && !handler_done && stack_ovf)
      |=> stop_state;
  endproperty
  a_stack_stop: assert property (p_stack_stop)
    else $error("stack overflow did not stop");

  property p_sel_end;
    (state == ST_SEL && pop && pop_vec == V_SEL)
      |=> stop_state && stop_cause == CAUSE_SELECTOR;
  endproperty
  a_sel_end: assert property (p_sel_end)
    else $error("handler 28 ended without stop");

  property p_lamp_mode;
    (stop_state && (stop_cause == CAUSE_SELECTOR ||
     stop_cause == CAUSE_BUS)) |=> stop_lamp;
  endproperty
  a_lamp_mode: assert property (p_lamp_mode)
    else $error("steady stop lamp not lit");

  property p_istack;
    (!stop_state && enter_stop && user_prog_entered &&
     enter_cause == CAUSE_INSTR) |=> istack_push && istack_addr ==
     $past(cur_addr) && istack_cause == CAUSE_INSTR;
  endproperty
  a_istack: assert property (p_istack)
    else $error("break record missing on stop");

  property p_ack_cont;
    (state == ST_RUN && clr_vec[V_ACK_IND] &&
     !handler_present[V_ACK_IND] && next_cause == CAUSE_NONE)
      |=> !stop_state && !handler_call;
  endproperty
  a_ack_cont: assert property (p_ack_cont)
    else $error("absent ack handler caused stop or call");

  property p_od_set;
    scan_overrun |=> output_disable ##1 scan_restart || output_disable;
  endproperty
  a_od_set: assert property (p_od_set)
    else $error("output disable not raised on overrun");

  property p_depth;
    do_call |-> nest_depth_q != NEST_MAX && !active[call_vec];
  endproperty
  a_depth: assert property (p_depth)
    else $error("handler call beyond nest depth or repeated");

  property p_pend_hold;
    1'b1 |=> (($past(pending & ~clr_vec) & ~pending) == '0);
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("latched fault lost before dispatch");

  property p_call_num;
    (do_call && call_vec == V_SCAN) |=> handler_call &&
      handler_num == fds_ob_num(V_SCAN) && !handler_skip;
  endproperty
  a_call_num: assert property (p_call_num)
    else $error("scan overrun handler number wrong");

  c_sel_call: cover property (do_call && call_vec == V_SEL);
  c_ack_cont: cover property (clr_vec[V_ACK_IMG] && !do_call);
  c_fast_stop: cover property (stop_state && lamp_mode == LAMP_FAST);
  c_nested: cover property (nest_depth_q == NEST_MAX);
endmodule : fds_fault_dispatch_stop_control

/* File: fds_fault_dispatch_stop_control_test.sv */
// self-checking bench for the fault dispatch and stop unit
`timescale 1ns/100ps
module fds_fault_dispatch_stop_control_test;
  import fds_pkg::*;
  localparam logic [7:0] OBN [12] = '{8'h13, 8'h17, 8'h18, 8'h19, 8'h1A,
    8'h1B, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22};
  logic clk = 1'b0, reset_n = 1'b0, bnd = 1'b1, upe = 1'b0, sel = 1'b0;
  logic coord = 1'b0, done = 1'b0, ios = 1'b0, img = 1'b0, hload = 1'b0;
  logic mute = 1'b0, s = 1'b0, run = 1'b1;
  logic [9:0] stp = 10'h000;
  logic [11:0] flt = 12'h000, dly = 12'h003;
  logic [NVEC-1:0] hpres = 13'h0000;
  logic [15:0] addr = 16'h0000, a1 = 16'h0000, a2 = 16'h0000;
  logic [7:0] cc = 8'h00;
  logic rdy, run_en, stop_st, lamp, odis, srst, iow, hcall, hskip, ipush;
  fds_cause_t cause, icause;
  logic [7:0] hnum, icc;
  logic [15:0] inf1, inf2, iaddr, iacc1, iacc2;
  logic [2:0] depth;
  int n_errors = 0, checks = 0, cyc = 0, seed = 55;

  fds_fault_dispatch_stop_control #(.FAST_HALF_CYC(4)) dut (
    .clk(clk), .reset_n(reset_n), .instr_boundary(bnd),
    .core_running(run), .user_prog_entered(upe),
    .selector_stop(sel), .coordinator_halt(coord), .stop_instr(stp[0]),
    .battery_fail(stp[1]), .central_power_fail(stp[2]),
    .expansion_power_fail(stp[3]), .interrupt_stack_overflow(stp[4]),
    .block_stack_overflow(stp[5]), .module_address_list_err(stp[6]),
    .loop_param_block_err(stp[7]), .preset_block_err(stp[8]),
    .init_err(stp[9]), .absent_block_call(flt[0]), .io_start(ios),
    .io_image(img), .module_ready(rdy), .address_error(flt[3]),
    .scan_overrun(flt[4]), .subst_error(flt[5]), .illegal_opcode(flt[6]),
    .illegal_param(flt[7]), .special_func_err(flt[8]),
    .transfer_err(flt[9]), .time_irq_overrun(flt[10]),
    .loop_ctrl_err(flt[11]), .handler_load(hload),
    .handler_present_in(hpres), .handler_done(done), .cur_addr(addr),
    .cur_cc(cc), .acc1(a1), .acc2(a2), .run_enable(run_en),
    .stop_state(stop_st), .stop_cause(cause), .stop_lamp(lamp),
    .output_disable(odis), .scan_restart(srst), .io_wait(iow),
    .handler_call(hcall), .handler_num(hnum), .handler_info1(inf1),
    .handler_info2(inf2), .handler_skip(hskip), .nest_depth(depth),
    .istack_push(ipush), .istack_addr(iaddr), .istack_cc(icc),
    .istack_acc1(iacc1), .istack_acc2(iacc2), .istack_cause(icause));

  fds_io_model io (.clk(clk), .reset_n(reset_n), .io_start(ios),
    .delay(dly), .mute(mute), .module_ready(rdy));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic logic [15:0] b1(input logic x);
    return {15'h0000, x};
  endfunction : b1

  // skipped vectors resume at the following instruction
  function automatic logic exp_skip(input int v);
    return v == 0 || v == 3 || (v >= 5 && v <= 9);
  endfunction : exp_skip

  function automatic fds_cause_t exp_cause(input int k);
    if (k == 0) return CAUSE_INSTR;
    if (k <= 3) return CAUSE_BUS;
    if (k <= 5) return CAUSE_STACK;
    if (k <= 8) return CAUSE_CONFIG;
    return CAUSE_INIT;
  endfunction : exp_cause

  task automatic wrap_up();
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic restart(input logic [NVEC-1:0] pres);
    reset_n = 1'b0;
    tick(20);
    reset_n = 1'b1;
    hpres = pres;
    hload = 1'b1;
    tick();
    hload = 1'b0;
  endtask : restart

  task automatic wait_call(input int n);
    s = 1'b0;
    for (int i = 0; i < n && !s; i++) begin
      tick();
      s = (hcall === 1'b1);
    end
  endtask : wait_call

  task automatic fire(input int v);
    flt[v] = 1'b1;
    tick();
    flt = 12'h000;
  endtask : fire

  // boundary dropped so the end pulse never competes with a dispatch
  task automatic end_handler();
    bnd = 1'b0;
    done = 1'b1;
    tick();
    done = 1'b0;
    bnd = 1'b1;
    tick();
  endtask : end_handler

  task automatic access(input logic im, input logic [11:0] d,
                        input logic m);
    img = im;
    dly = d;
    mute = m;
    ios = 1'b1;
    tick();
    ios = 1'b0;
    chk(b1(iow), 16'h0001);
    for (int i = 0; i < 2600 && iow === 1'b1; i++) tick();
    chk(b1(iow), 16'h0000);
    wait_call(4);
  endtask : access

  task automatic lamp_is(input fds_lamp_t m);
    int t;
    logic last;
    logic [1:0] got;
    t = 0;
    last = lamp;
    repeat (64) begin
      tick();
      if (lamp !== last) t++;
      last = lamp;
    end
    got = (t == 0 && lamp === 1'b1) ? LAMP_STEADY :
          (t <= 8) ? LAMP_SLOW : LAMP_FAST;
    chk({14'h0000, got}, {14'h0000, m});
  endtask : lamp_is

  initial begin
    restart(13'h1FFF);
    for (int v = 0; v < 12; v++) begin
      if (v == 1 || v == 2) continue;
      addr = 16'($random(seed));
      fire(v);
      if (v == 4) chk(b1(srst), 16'h0001);
      wait_call(8);
      chk({8'h00, hnum}, {8'h00, OBN[v]});
      chk(inf1, {5'h00, OBN[v], 3'h0});
      chk(inf2, addr);
      chk(b1(hskip), b1(exp_skip(v)));
      if (v == 4) chk(b1(odis), 16'h0001);
      end_handler();
      chk({13'h0000, depth}, 16'h0000);
      chk(b1(odis), 16'h0000);
    end
    flt[6] = 1'b1;
    fire(7);
    wait_call(8);
    chk({8'h00, hnum}, 16'h001D);
    end_handler();
    wait_call(8);
    chk({8'h00, hnum}, 16'h001E);
    fire(7);
    tick(8);
    chk(b1(stop_st), 16'h0001);
    restart(13'h1FFF);
    for (int v = 3; v < 10; v++) fire(v);
    tick(10);
    chk({13'h0000, depth}, 16'h0007);
    fire(10);
    tick(4);
    chk(b1(stop_st), 16'h0001);
    restart(13'h1FFF);
    access(1'b0, 12'h003, 1'b0);
    chk(b1(s), 16'h0000);
    access(1'b0, 12'h7D0, 1'b0);
    chk(b1(s), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      access(k[0], 12'($random(seed) & 32'h7FF), 1'b1);
      chk({8'h00, hnum}, {8'h00, OBN[k + 1]});
      chk(b1(hskip), 16'h0000);
      end_handler();
    end
    restart(13'h0000);
    access(1'b0, 12'h003, 1'b1);
    chk(b1(s | stop_st), 16'h0000);
    fire(6);
    tick(8);
    chk(b1(stop_st), 16'h0001);
    chk(16'(cause), 16'(CAUSE_FAULT));
    for (int k = 0; k < 2; k++) begin
      restart(13'h1FFF);
      if (k == 0) sel = 1'b1;
      else coord = 1'b1;
      wait_call(8);
      chk({8'h00, hnum}, 16'h001C);
      sel = 1'b0;
      coord = 1'b0;
      fire(7);
      wait_call(8);
      chk({8'h00, hnum}, 16'h001E);
      end_handler();
      chk(b1(stop_st), 16'h0000);
      end_handler();
      chk(b1(stop_st), 16'h0001);
      chk(16'(cause), 16'(CAUSE_SELECTOR));
      lamp_is(LAMP_STEADY);
    end
    for (int k = 0; k < 10; k++) begin
      restart(13'h1FFF);
      addr = 16'($random(seed));
      cc = 8'($random(seed));
      a1 = 16'($random(seed));
      a2 = 16'($random(seed));
      upe = 1'b1;
      bnd = k[0];
      run = k[0];
      stp[k] = 1'b1;
      s = 1'b0;
      repeat (8) begin
        tick();
        s = s | (ipush === 1'b1);
      end
      chk(b1(stop_st & ~run_en), 16'h0001);
      chk(16'(cause), 16'(exp_cause(k)));
      chk(b1(s), b1(k < 6));
      if (k < 6) chk(iaddr ^ iacc1 ^ iacc2, addr ^ a1 ^ a2);
      if (k < 6) chk({8'h00, icc}, {8'h00, cc});
      if (k < 6) chk(16'(icause), 16'(exp_cause(k)));
      lamp_is(k == 9 ? LAMP_FAST : (exp_cause(k) == CAUSE_BUS) ?
              LAMP_STEADY : LAMP_SLOW);
      stp = 10'h000;
    end
    wrap_up();
  end
endmodule : fds_fault_dispatch_stop_control_test

/* File: fds_io_model.sv */
// behavioural i/o module answering addressed accesses with ready
`timescale 1ns/100ps
module fds_io_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_start,
  input wire logic [11:0] delay,
  input wire logic mute,
  output logic module_ready
);
  logic [11:0] cnt;
  logic busy;
  // mute stands for a pulled or broken module that never answers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 12'h000;
      busy <= 1'b0;
      module_ready <= 1'b0;
    end else if (io_start) begin
      cnt <= 12'h000;
      busy <= 1'b1;
      module_ready <= 1'b0;
    end else if (busy) begin
      cnt <= cnt + 12'h001;
      if (cnt == delay) module_ready <= !mute;
      if (cnt == delay + 12'h002) begin
        busy <= 1'b0;
        module_ready <= 1'b0;
      end
    end
  end
endmodule : fds_io_model

/* File: fds_lamp.sv */
// stop lamp driver with flash-rate enable dividers
`timescale 1ns/100ps
module fds_lamp
  import fds_pkg::*;
#(
  parameter int FAST_HALF_CYC = FLASH_FAST_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input fds_lamp_t mode,
  output logic lamp
);
  logic [FLASH_CNT_W-1:0] div;
  logic [1:0] slow_div;
  logic fast_tick;
  logic fast_ph;
  logic slow_ph;

  assign fast_tick = (div == FLASH_CNT_W'(FAST_HALF_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div <= '0;
    else if (fast_tick) div <= '0;
    else div <= div + 1'b1;
  end

  // slow rate is derived from the fast tick so both phases stay aligned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_ph <= 1'b0;
      slow_ph <= 1'b0;
      slow_div <= '0;
    end else if (fast_tick) begin
      fast_ph <= ~fast_ph;
      slow_div <= slow_div + 1'b1;
      if (slow_div == FLASH_SLOW_LAST) slow_ph <= ~slow_ph;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lamp <= 1'b0;
    else begin
      case (mode)
        LAMP_STEADY: lamp <= 1'b1;
        LAMP_SLOW: lamp <= slow_ph;
        LAMP_FAST: lamp <= fast_ph;
        default: lamp <= 1'b0;
      endcase
    end
  end
endmodule : fds_lamp

/* File: fds_pkg.sv */
// shared constants and types for the fault dispatch and stop unit
package fds_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACK_TIMEOUT_NS = 20000;
  localparam int ACK_TIMEOUT_CYC =
    (ACK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_CNT_W = 12;
  localparam int FLASH_FAST_HALF_NS = 62500000;
  localparam int FLASH_FAST_HALF_CYC = FLASH_FAST_HALF_NS / CLK_PERIOD_NS;
  localparam int FLASH_CNT_W = 24;
  localparam logic [1:0] FLASH_SLOW_LAST = 2'h3;
  localparam int DEPTH_W = 3;
  localparam logic [DEPTH_W-1:0] NEST_MAX = 3'h7;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 3'h1;
  localparam int NVEC = 13;
  localparam int VEC_W = 4;
  localparam int WORD_W = 16;
  localparam int CC_W = 8;
  localparam int OB_W = 8;
  localparam logic [VEC_W-1:0] V_ABSENT = 4'h0;
  localparam logic [VEC_W-1:0] V_ACK_IND = 4'h1;
  localparam logic [VEC_W-1:0] V_ACK_IMG = 4'h2;
  localparam logic [VEC_W-1:0] V_ADDR = 4'h3;
  localparam logic [VEC_W-1:0] V_SCAN = 4'h4;
  localparam logic [VEC_W-1:0] V_SUBST = 4'h5;
  localparam logic [VEC_W-1:0] V_OPCODE = 4'h6;
  localparam logic [VEC_W-1:0] V_PARAM = 4'h7;
  localparam logic [VEC_W-1:0] V_SFUNC = 4'h8;
  localparam logic [VEC_W-1:0] V_XFER = 4'h9;
  localparam logic [VEC_W-1:0] V_TIRQ = 4'hA;
  localparam logic [VEC_W-1:0] V_LOOP = 4'hB;
  localparam logic [VEC_W-1:0] V_SEL = 4'hC;
  // vectors whose missing handler means carry on instead of stop
  localparam logic [NVEC-1:0] CONT_MASK = 13'h0006;
  // vectors whose faulting instruction is skipped, resume at the next one
  localparam logic [NVEC-1:0] SKIP_MASK = 13'h03E9;

  function automatic logic [OB_W-1:0] fds_ob_num(input logic [VEC_W-1:0] v);
    case (v)
      V_ABSENT: return 8'h13;
      V_ACK_IND: return 8'h17;
      V_ACK_IMG: return 8'h18;
      V_ADDR: return 8'h19;
      V_SCAN: return 8'h1A;
      V_SUBST: return 8'h1B;
      V_SEL: return 8'h1C;
      V_OPCODE: return 8'h1D;
      V_PARAM: return 8'h1E;
      V_SFUNC: return 8'h1F;
      V_XFER: return 8'h20;
      V_TIRQ: return 8'h21;
      V_LOOP: return 8'h22;
      default: return 8'h00;
    endcase
  endfunction : fds_ob_num

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000, CAUSE_SELECTOR = 3'b001, CAUSE_INSTR = 3'b010,
    CAUSE_BUS = 3'b011, CAUSE_STACK = 3'b100, CAUSE_CONFIG = 3'b101,
    CAUSE_INIT = 3'b110, CAUSE_FAULT = 3'b111
  } fds_cause_t;

  typedef enum logic [1:0] {
    LAMP_OFF = 2'b00, LAMP_STEADY = 2'b01, LAMP_SLOW = 2'b10,
    LAMP_FAST = 2'b11
  } fds_lamp_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_SEL = 2'b01, ST_STOP = 2'b10
  } fds_state_t;
endpackage : fds_pkg
